//--- design/mcdm_pkg.sv
// register map, field layout, reset values and types of the commutation delay manager
package mcdm_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int TIMER_W = 8;
	localparam int RATIO_W = 4;
	localparam int PRESC_W = 16;

	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_RATIO     = 8'h04;
	localparam logic [7:0] ADDR_STATUS    = 8'h08;
	localparam logic [7:0] ADDR_MASK      = 8'h0c;
	localparam logic [7:0] ADDR_REQUEST   = 8'h10;
	localparam logic [7:0] ADDR_TIMER     = 8'h14;
	localparam logic [7:0] ADDR_COMPARE   = 8'h18;
	localparam logic [7:0] ADDR_DEMAG     = 8'h1c;
	localparam logic [7:0] ADDR_LATEST    = 8'h20;
	localparam logic [7:0] ADDR_PREVIOUS  = 8'h24;
	localparam logic [7:0] ADDR_WEIGHT    = 8'h28;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// control register, bit 0 is clock_enable
	typedef struct packed {
		logic [1:0] speed_sensor_select;
		logic       interval_selector;
		logic       software_commutation_enable;
		logic       auto_switch_select;
		logic       clock_enable;
	} mcdm_ctrl_t;

	// status and mask share this layout, bit 0 is commutation_flag
	typedef struct packed {
		logic demag_flag;
		logic zero_flag;
		logic ratio_dec_flag;
		logic ratio_inc_flag;
		logic timer_overflow_flag;
		logic commutation_flag;
	} mcdm_irq_t;

	localparam int CTRL_W = $bits(mcdm_ctrl_t);
	localparam int IRQ_W  = $bits(mcdm_irq_t);

	localparam mcdm_ctrl_t       CTRL_RST   = '0;
	localparam mcdm_irq_t        IRQ_RST    = '0;
	localparam logic [RATIO_W-1:0] RATIO_RST  = 4'h0;
	localparam logic [RATIO_W-1:0] RATIO_MAX  = 4'hf;
	localparam logic [TIMER_W-1:0] TIMER_RST  = 8'h00;
	localparam logic [TIMER_W-1:0] TIMER_TOP  = 8'hff;
	localparam logic [TIMER_W-1:0] WEIGHT_RST = 8'h00;
	localparam logic [1:0]         TES_NONE   = 2'b00;

	typedef enum logic [1:0] {
		MS_IDLE = 2'b01,
		MS_MULT = 2'b10
	} mcdm_state_t;
endpackage

//--- design/mcdm_delay_manager.sv
// commutation delay manager: step timer, captures, multiplier, axi4-lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mcdm_delay_manager (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [mcdm_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [mcdm_pkg::DATA_W-1:0] wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [mcdm_pkg::ADDR_W-1:0] araddr,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic [mcdm_pkg::DATA_W-1:0]      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	input  wire logic                        zero_cross_evt,
	input  wire logic                        demag_evt,
	output logic                             commutation_evt,
	output logic                             irq
);
	localparam int TW = mcdm_pkg::TIMER_W;

	function automatic logic is_mapped(input logic [mcdm_pkg::ADDR_W-1:0] a);
		unique case (a)
			mcdm_pkg::ADDR_CTRL, mcdm_pkg::ADDR_RATIO, mcdm_pkg::ADDR_STATUS,
			mcdm_pkg::ADDR_MASK, mcdm_pkg::ADDR_REQUEST, mcdm_pkg::ADDR_TIMER,
			mcdm_pkg::ADDR_COMPARE, mcdm_pkg::ADDR_DEMAG, mcdm_pkg::ADDR_LATEST,
			mcdm_pkg::ADDR_PREVIOUS, mcdm_pkg::ADDR_WEIGHT: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// up halves the value (slower clock), down doubles it
	function automatic logic [TW-1:0] shift_val(input logic [TW-1:0] v, input logic up,
			input logic dn);
		if (up) begin
			shift_val = v >> 1;
		end else if (dn) begin
			shift_val = v << 1;
		end else begin
			shift_val = v;
		end
	endfunction

	logic                                aw_held_r;
	logic                                w_held_r;
	logic [mcdm_pkg::ADDR_W-1:0]         aw_addr_r;
	logic [mcdm_pkg::DATA_W-1:0]         w_data_r;
	logic                                w_lane_r;
	logic                                bvalid_r;
	logic [1:0]                          bresp_r;
	logic                                rvalid_r;
	logic [1:0]                          rresp_r;
	logic [mcdm_pkg::DATA_W-1:0]         rdata_r;
	logic [mcdm_pkg::DATA_W-1:0]         rd_word;
	logic                                wr_fire;
	logic                                wr_en;

	mcdm_pkg::mcdm_ctrl_t                ctrl_r;
	mcdm_pkg::mcdm_irq_t                 status_r;
	mcdm_pkg::mcdm_irq_t                 mask_r;
	mcdm_pkg::mcdm_irq_t                 status_set;
	mcdm_pkg::mcdm_irq_t                 status_clr;
	mcdm_pkg::mcdm_state_t               state_r;
	logic [mcdm_pkg::RATIO_W-1:0]        step_ratio_r;
	logic [mcdm_pkg::PRESC_W-1:0]        presc_cnt_r;
	logic [TW-1:0]                       step_timer_r;
	logic [TW-1:0]                       commutation_compare_r;
	logic [TW-1:0]                       demag_capture_compare_r;
	logic [TW-1:0]                       latest_zero_interval_r;
	logic [TW-1:0]                       previous_zero_interval_r;
	logic [TW-1:0]                       phase_weight_r;
	logic                                armed_r;
	logic                                demag_armed_r;
	logic                                ratio_increment_request_r;
	logic                                ratio_decrement_request_r;
	logic                                commut_r;

	logic                                running;
	logic                                switched;
	logic                                speed_mode;
	logic                                tick;
	logic                                commut;
	logic                                ovf;
	logic                                zero_go;
	logic                                shift_up;
	logic                                shift_dn;
	logic                                mult_load;
	logic                                early;
	logic                                req_wr;
	logic [2*TW-1:0]                     product;
	logic [TW-1:0]                       prod_hi;

	// axi4-lite write channel: address and data taken in either order
	assign awready = !aw_held_r;
	assign wready  = !w_held_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign wr_en   = wr_fire && w_lane_r && is_mapped(aw_addr_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= '0;
			w_lane_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= mcdm_pkg::RESP_OKAY;
		end else begin
			if (awvalid && !aw_held_r) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= awaddr;
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (wvalid && !w_held_r) begin
				w_held_r <= 1'b1;
				w_data_r <= wdata;
				w_lane_r <= wstrb[0];
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r  <= is_mapped(aw_addr_r) ? mcdm_pkg::RESP_OKAY : mcdm_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// axi4-lite read channel
	assign arready = !rvalid_r;
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = rdata_r;

	always_comb begin
		rd_word = '0;
		unique case (araddr)
			mcdm_pkg::ADDR_CTRL:     rd_word[mcdm_pkg::CTRL_W-1:0] = ctrl_r;
			mcdm_pkg::ADDR_RATIO:    rd_word[mcdm_pkg::RATIO_W-1:0] = step_ratio_r;
			mcdm_pkg::ADDR_STATUS:   rd_word[mcdm_pkg::IRQ_W-1:0] = status_r;
			mcdm_pkg::ADDR_MASK:     rd_word[mcdm_pkg::IRQ_W-1:0] = mask_r;
			mcdm_pkg::ADDR_REQUEST:  rd_word[1:0] = {ratio_decrement_request_r,
					ratio_increment_request_r};
			mcdm_pkg::ADDR_TIMER:    rd_word[TW-1:0] = step_timer_r;
			mcdm_pkg::ADDR_COMPARE:  rd_word[TW-1:0] = commutation_compare_r;
			mcdm_pkg::ADDR_DEMAG:    rd_word[TW-1:0] = demag_capture_compare_r;
			mcdm_pkg::ADDR_LATEST:   rd_word[TW-1:0] = latest_zero_interval_r;
			mcdm_pkg::ADDR_PREVIOUS: rd_word[TW-1:0] = previous_zero_interval_r;
			mcdm_pkg::ADDR_WEIGHT:   rd_word[TW-1:0] = phase_weight_r;
			default:                 rd_word = '0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= mcdm_pkg::RESP_OKAY;
			rdata_r  <= '0;
		end else if (arvalid && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= is_mapped(araddr) ? mcdm_pkg::RESP_OKAY : mcdm_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// timing core
	assign running    = ctrl_r.clock_enable;
	assign switched   = !ctrl_r.auto_switch_select;
	assign speed_mode = ctrl_r.speed_sensor_select != mcdm_pkg::TES_NONE;
	assign tick       = running && (presc_cnt_r ==
			mcdm_pkg::PRESC_W'((32'h1 << step_ratio_r) - 32'h1));
	assign zero_go    = running && zero_cross_evt;
	assign req_wr     = wr_en && aw_addr_r == mcdm_pkg::ADDR_REQUEST;

	assign product   = {8'h00, phase_weight_r} * {8'h00, (ctrl_r.interval_selector ?
			latest_zero_interval_r : previous_zero_interval_r)};
	assign prod_hi   = product[2*TW-1:TW];
	assign mult_load = state_r == mcdm_pkg::MS_MULT && !switched &&
			!ctrl_r.software_commutation_enable;
	assign early     = prod_hi <= step_timer_r;

	assign commut = running && !speed_mode && (
			(tick && armed_r && step_timer_r == commutation_compare_r) ||
			(mult_load && early));
	assign ovf    = tick && step_timer_r == mcdm_pkg::TIMER_TOP && !commut;
	assign shift_up = commut && switched && ratio_increment_request_r &&
			step_ratio_r != mcdm_pkg::RATIO_MAX;
	assign shift_dn = commut && switched && ratio_decrement_request_r &&
			step_ratio_r != mcdm_pkg::RATIO_RST;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= mcdm_pkg::MS_IDLE;
		end else begin
			unique case (state_r)
				mcdm_pkg::MS_IDLE: begin
					if (zero_go && !switched && !speed_mode) begin
						state_r <= mcdm_pkg::MS_MULT;
					end
				end
				mcdm_pkg::MS_MULT: begin
					state_r <= mcdm_pkg::MS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_cnt_r <= '0;
		end else if (!running || tick || commut || (zero_go && !switched)) begin
			presc_cnt_r <= '0;
		end else begin
			presc_cnt_r <= presc_cnt_r + mcdm_pkg::PRESC_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r         <= mcdm_pkg::CTRL_RST;
			mask_r         <= mcdm_pkg::IRQ_RST;
			phase_weight_r <= mcdm_pkg::WEIGHT_RST;
		end else if (wr_en) begin
			if (aw_addr_r == mcdm_pkg::ADDR_CTRL) begin
				ctrl_r <= w_data_r[mcdm_pkg::CTRL_W-1:0];
			end
			if (aw_addr_r == mcdm_pkg::ADDR_MASK) begin
				mask_r <= w_data_r[mcdm_pkg::IRQ_W-1:0];
			end
			if (aw_addr_r == mcdm_pkg::ADDR_WEIGHT) begin
				phase_weight_r <= w_data_r[TW-1:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_ratio_r <= mcdm_pkg::RATIO_RST;
		end else if (wr_en && aw_addr_r == mcdm_pkg::ADDR_RATIO && !running) begin
			step_ratio_r <= w_data_r[mcdm_pkg::RATIO_W-1:0];
		end else if (shift_up) begin
			step_ratio_r <= step_ratio_r + 4'h1;
		end else if (shift_dn) begin
			step_ratio_r <= step_ratio_r - 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ratio_increment_request_r <= 1'b0;
			ratio_decrement_request_r <= 1'b0;
		end else if (req_wr && !(w_data_r[0] && w_data_r[1])) begin
			ratio_increment_request_r <= w_data_r[0];
			ratio_decrement_request_r <= w_data_r[1];
		end else if (commut && switched) begin
			ratio_increment_request_r <= 1'b0;
			ratio_decrement_request_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_timer_r <= mcdm_pkg::TIMER_RST;
		end else if (!running) begin
			if (wr_en && aw_addr_r == mcdm_pkg::ADDR_TIMER) begin
				step_timer_r <= w_data_r[TW-1:0];
			end
		end else if (commut && switched && !speed_mode) begin
			step_timer_r <= mcdm_pkg::TIMER_RST;
		end else if (zero_go && !switched) begin
			step_timer_r <= mcdm_pkg::TIMER_RST;
		end else if (tick) begin
			step_timer_r <= step_timer_r + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latest_zero_interval_r   <= mcdm_pkg::TIMER_RST;
			previous_zero_interval_r <= mcdm_pkg::TIMER_RST;
		end else if (zero_go) begin
			latest_zero_interval_r   <= step_timer_r;
			previous_zero_interval_r <= latest_zero_interval_r;
		end else if (!running && wr_en) begin
			if (aw_addr_r == mcdm_pkg::ADDR_LATEST) begin
				latest_zero_interval_r <= w_data_r[TW-1:0];
			end
			if (aw_addr_r == mcdm_pkg::ADDR_PREVIOUS) begin
				previous_zero_interval_r <= w_data_r[TW-1:0];
			end
		end else begin
			latest_zero_interval_r   <= shift_val(latest_zero_interval_r, shift_up, shift_dn);
			previous_zero_interval_r <= shift_val(previous_zero_interval_r, shift_up,
					shift_dn);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			demag_capture_compare_r <= mcdm_pkg::TIMER_RST;
			demag_armed_r           <= 1'b0;
		end else if (wr_en && aw_addr_r == mcdm_pkg::ADDR_DEMAG) begin
			demag_capture_compare_r <= w_data_r[TW-1:0];
			demag_armed_r           <= 1'b1;
		end else if (running && demag_evt) begin
			demag_capture_compare_r <= step_timer_r;
			demag_armed_r           <= 1'b0;
		end else if (tick && demag_armed_r && step_timer_r == demag_capture_compare_r) begin
			demag_armed_r <= 1'b0;
		end else begin
			demag_capture_compare_r <= shift_val(demag_capture_compare_r, shift_up,
					shift_dn);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			commutation_compare_r <= mcdm_pkg::TIMER_RST;
			armed_r               <= 1'b0;
		end else if (wr_en && aw_addr_r == mcdm_pkg::ADDR_COMPARE) begin
			commutation_compare_r <= w_data_r[TW-1:0];
			armed_r               <= 1'b1;
		end else if (mult_load) begin
			commutation_compare_r <= early ? step_timer_r : prod_hi;
			armed_r               <= !early;
		end else begin
			commutation_compare_r <= shift_val(commutation_compare_r, shift_up,
					shift_dn);
			if (commut && !switched) begin
				armed_r <= 1'b0;
			end
		end
	end

	// sticky status, set wins over a write-one clear
	always_comb begin
		status_set = mcdm_pkg::IRQ_RST;
		status_set.commutation_flag    = commut;
		status_set.timer_overflow_flag = ovf && !speed_mode;
		status_set.ratio_inc_flag      = shift_up;
		status_set.ratio_dec_flag      = shift_dn;
		status_set.zero_flag           = zero_go;
		status_set.demag_flag          = running && (demag_evt || (tick && demag_armed_r &&
				step_timer_r == demag_capture_compare_r));
		status_clr = mcdm_pkg::IRQ_RST;
		if (wr_en && aw_addr_r == mcdm_pkg::ADDR_STATUS) begin
			status_clr = w_data_r[mcdm_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r <= mcdm_pkg::IRQ_RST;
			commut_r <= 1'b0;
		end else begin
			status_r <= (status_r & ~status_clr) | status_set;
			commut_r <= commut;
		end
	end

	assign irq             = |(status_r & mask_r);
	assign commutation_evt = commut_r;

	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_ratio_locked: assert property (running && !commut |=> $stable(step_ratio_r))
		else $error("step ratio changed while running");
	a_switch_reset: assert property (commut && switched |=> step_timer_r == 8'h00 &&
			commutation_evt)
		else $error("switched commutation did not reset timer");
	a_commut_flag: assert property (commut ##1 mask_r.commutation_flag |->
			status_r.commutation_flag && irq)
		else $error("commutation flag or irq missing");
	a_no_arm: assert property (!armed_r && state_r != mcdm_pkg::MS_MULT |-> !commut)
		else $error("commutation without armed compare");
	a_both_req: assert property (req_wr && w_data_r[1:0] == 2'b11 && !commut |=>
			$stable({ratio_increment_request_r, ratio_decrement_request_r}))
		else $error("double request write was taken");
	a_overflow_wrap: assert property (ovf && !speed_mode |=> step_timer_r == 8'h00 &&
			status_r.timer_overflow_flag)
		else $error("overflow did not wrap or flag");
	a_zero_capture: assert property (zero_go && !switched |=>
			latest_zero_interval_r == $past(step_timer_r) && step_timer_r == 8'h00 &&
			previous_zero_interval_r == $past(latest_zero_interval_r))
		else $error("zero capture wrong");
	a_switched_zero: assert property (running && switched && zero_go && !tick &&
			!commut |=> $stable(step_timer_r))
		else $error("zero event moved timer in switched mode");
	a_speed_quiet: assert property (speed_mode |-> !commut)
		else $error("commutation in speed mode");
	a_mult_load: assert property (mult_load && !early |=>
			commutation_compare_r == $past(prod_hi) && armed_r)
		else $error("hardware compare not loaded");
	a_shift_sync: assert property (shift_up && !zero_go && !wr_en |=>
			step_ratio_r == $past(step_ratio_r) + 4'h1 &&
			latest_zero_interval_r == ($past(latest_zero_interval_r) >> 1) &&
			!ratio_increment_request_r)
		else $error("ratio increment shift wrong");

	c_switched_commut: cover property (commut && switched);
	c_hw_commut: cover property (mult_load ##[1:300] commut);
	c_ratio_up: cover property (shift_up);
	c_overflow: cover property (ovf);
endmodule
`default_nettype wire

//--- verif/mcdm_input_detect.sv
// input detection model: registers bench requests, gated by aresetn, into event pulses one cycle later
`timescale 1ns/1ps
`default_nettype none
module mcdm_input_detect (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic fire_zero,
	input  wire logic fire_demag,
	output var logic  zero_cross_evt,
	output var logic  demag_evt
);
	always_ff @(posedge aclk) begin
		zero_cross_evt <= aresetn & fire_zero;
		demag_evt      <= aresetn & fire_demag;
	end
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench of the commutation delay manager
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rd, rdata;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, commutation_evt, irq;
	logic [1:0]  bresp, rresp, rs;
	logic        fire_zero = 0, fire_demag = 0, zero_cross_evt, demag_evt;
	int          n_errors = 0, comparisons = 0, cyc = 0, seed = 32'h19e1;
	int          exp_cmp, exp_ratio, i, exp_t, exp_l, exp_w;
	mcdm_delay_manager u_mcdm_delay_manager (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .zero_cross_evt(zero_cross_evt), .demag_evt(demag_evt),
		.commutation_evt(commutation_evt), .irq(irq));
	mcdm_input_detect u_mcdm_input_detect (.aclk(aclk), .aresetn(aresetn),
		.fire_zero(fire_zero), .fire_demag(fire_demag),
		.zero_cross_evt(zero_cross_evt), .demag_evt(demag_evt));
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// hang guard, well above the longest expected run
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic a_ok, w_ok;
		a_ok = 0;
		w_ok = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(a_ok && w_ok)) begin
			@(posedge aclk);
			if (awready && !a_ok) begin
				a_ok = 1;
				awvalid <= 0;
			end
			if (wready && !w_ok) begin
				w_ok = 1;
				wvalid <= 0;
			end
		end
		while (!bvalid) @(posedge aclk);
		bready <= 0;
	endtask
	task automatic rdreg(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		while (!rvalid) @(posedge aclk);
		rd = rdata;
		rs = rresp;
		rready <= 0;
	endtask
	// one-cycle request to the input detection model, zero event if z else demag
	task automatic pulse(input logic z);
		@(posedge aclk);
		fire_zero <= z;
		fire_demag <= !z;
		@(posedge aclk);
		fire_zero <= 0;
		fire_demag <= 0;
	endtask
	task automatic wait_com(input int limit);
		for (i = 0; i < limit && commutation_evt !== 1'b1; i++) @(posedge aclk);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		rdreg(mcdm_pkg::ADDR_CTRL);
		chk(rd, 32'h0);
		rdreg(8'h3c);
		chk({30'h0, rs}, {30'h0, mcdm_pkg::RESP_SLVERR});
		exp_ratio = 1;
		wr(mcdm_pkg::ADDR_RATIO, 32'h1);
		wr(mcdm_pkg::ADDR_CTRL, 32'h5);
		wr(mcdm_pkg::ADDR_RATIO, 32'h9);
		rdreg(mcdm_pkg::ADDR_RATIO);
		chk(rd, exp_ratio);
		repeat (600) @(posedge aclk);
		rdreg(mcdm_pkg::ADDR_STATUS);
		chk(rd & 32'h3, 32'h2);
		wr(mcdm_pkg::ADDR_STATUS, 32'h3f);
		wr(mcdm_pkg::ADDR_REQUEST, 32'h3);
		rdreg(mcdm_pkg::ADDR_REQUEST);
		chk(rd, 32'h0);
		wr(mcdm_pkg::ADDR_REQUEST, 32'h1);
		wr(mcdm_pkg::ADDR_REQUEST, 32'h3);
		rdreg(mcdm_pkg::ADDR_REQUEST);
		chk(rd, 32'h1);
		wr(mcdm_pkg::ADDR_MASK, 32'h1);
		exp_cmp = 8 + ($random(seed) & 7);
		wr(mcdm_pkg::ADDR_COMPARE, exp_cmp);
		wait_com(700);
		chk({31'h0, commutation_evt}, 32'h1);
		exp_ratio = exp_ratio + 1;
		exp_cmp = exp_cmp >> 1;
		rdreg(mcdm_pkg::ADDR_STATUS);
		chk(rd & 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rdreg(mcdm_pkg::ADDR_RATIO);
		chk(rd, exp_ratio);
		rdreg(mcdm_pkg::ADDR_COMPARE);
		chk(rd, exp_cmp);
		rdreg(mcdm_pkg::ADDR_REQUEST);
		chk(rd, 32'h0);
		pulse(1'b1);
		repeat (3) @(posedge aclk);
		rdreg(mcdm_pkg::ADDR_STATUS);
		chk(rd & 32'h10, 32'h10);
		// speed mode first, so no commutation can re-set the flag before the irq check
		wr(mcdm_pkg::ADDR_CTRL, 32'h15);
		wr(mcdm_pkg::ADDR_STATUS, 32'h3f);
		chk({31'h0, irq}, 32'h0);
		wait_com(1200);
		chk({31'h0, commutation_evt}, 32'h0);
		rdreg(mcdm_pkg::ADDR_STATUS);
		chk(rd & 32'h3, 32'h0);
		// autoswitched: the slowest ratio ticks the timer only once in 32768 cycles so captures are predictable
		wr(mcdm_pkg::ADDR_CTRL, 32'h0);
		exp_t = $random(seed) & 8'hff;
		exp_l = 8'h40 | ($random(seed) & 8'h3f);
		exp_w = 8'h80 | ($random(seed) & 8'h7f);
		wr(mcdm_pkg::ADDR_RATIO, 32'hf);
		wr(mcdm_pkg::ADDR_TIMER, exp_t);
		wr(mcdm_pkg::ADDR_LATEST, exp_l);
		wr(mcdm_pkg::ADDR_WEIGHT, exp_w);
		wr(mcdm_pkg::ADDR_CTRL, 32'h3);
		wr(mcdm_pkg::ADDR_STATUS, 32'h3f);
		pulse(1'b0);
		repeat (3) @(posedge aclk);
		rdreg(mcdm_pkg::ADDR_DEMAG);
		chk(rd, exp_t);
		pulse(1'b1);
		repeat (3) @(posedge aclk);
		rdreg(mcdm_pkg::ADDR_LATEST);
		chk(rd, exp_t);
		rdreg(mcdm_pkg::ADDR_PREVIOUS);
		chk(rd, exp_l);
		rdreg(mcdm_pkg::ADDR_TIMER);
		chk(rd, 32'h0);
		rdreg(mcdm_pkg::ADDR_COMPARE);
		chk(rd, (exp_w * exp_l) >> 8);
		rdreg(mcdm_pkg::ADDR_STATUS);
		chk(rd & 32'h31, 32'h30);
		// zero weight gives a result not above the timer: immediate commutation
		wr(mcdm_pkg::ADDR_WEIGHT, 32'h0);
		pulse(1'b1);
		wait_com(20);
		chk({31'h0, commutation_evt}, 32'h1);
		rdreg(mcdm_pkg::ADDR_COMPARE);
		chk(rd, 32'h0);
		rdreg(mcdm_pkg::ADDR_PREVIOUS);
		chk(rd, exp_t);
		report_and_stop();
	end
endmodule
`default_nettype wire
